// ---- peripheral_bus_bridge.sv ----
// Main-bus to peripheral-bus bridge with clock synchronisation
`timescale 1ns/10ps
module peripheral_bus_bridge (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        reqValid,
  input  wire logic [31:0] reqAddr,
  input  wire logic        reqWrite,
  input  wire logic [1:0]  reqSize,
  input  wire logic [31:0] reqWdata,
  input  wire logic        busContend,
  input  wire logic        coreSlower,
  input  wire logic [3:0]  divA,
  input  wire logic [3:0]  divB,
  input  wire logic [3:0]  divF,
  input  wire logic [3:0]  divExt,
  input  wire logic        tgtAck,
  input  wire logic [31:0] tgtRdata,
  output logic             reqAck,
  output logic [31:0]      rdata,
  output logic             tgtValid,
  output logic [2:0]       tgtBus,
  output logic [31:0]      tgtAddr,
  output logic             tgtWrite,
  output logic [1:0]       tgtSize,
  output logic [31:0]      tgtWdata
);
  typedef enum logic [2:0] {IDLE, MAIN, SYNC, PERIPH, INTERRUPT_CONTROL_UNIT} fsm_t;

  typedef struct packed {
    fsm_t        fsm;
    logic        ack;
    logic [31:0] rdata;
    logic        tValid;
    logic [2:0]  tBus;
    logic [31:0] tAddr;
    logic        tWrite;
    logic [1:0]  tSize;
    logic [31:0] tWdata;
    logic [1:0]  clkSel;
    logic        sync;
    logic        interrupt_control_unit;
    logic        edgeSeen;
    logic [4:0]  cnt;
  } state_t;

  state_t                    st;
  state_t                    next_st;
  logic [bridge_pkg::NUM_CLKS-1:0] en;
  logic [bridge_pkg::NUM_CLKS-1:0][3:0] divs;
  logic                      effEn;

  ////////////////////////////////////////////////////////////////////////////
  // Address decoding

  function automatic logic [2:0] busOf(input logic [31:0] a);
    if (a >= bridge_pkg::EXT_BASE && a <= bridge_pkg::EXT_LAST) begin
      busOf = bridge_pkg::BUS_EXT;
    end else if (a > bridge_pkg::EXT_LAST) begin
      busOf = bridge_pkg::BUS_NONE;
    end else if (a >= bridge_pkg::BUS6_BASE) begin
      busOf = 3'h6;
    end else if (a >= bridge_pkg::BUS5_BASE) begin
      busOf = 3'h5;
    end else if (a >= bridge_pkg::BUS4_BASE) begin
      busOf = 3'h4;
    end else if (a >= bridge_pkg::BUS3_BASE) begin
      busOf = 3'h3;
    end else if (a >= bridge_pkg::BUS2_BASE) begin
      busOf = 3'h2;
    end else if (a >= bridge_pkg::BUS1_BASE) begin
      busOf = 3'h1;
    end else begin
      busOf = bridge_pkg::BUS_NONE;
    end
  endfunction

  function automatic logic isIcuB(input logic [31:0] a);
    isIcuB = (a >= bridge_pkg::ICU_B_FIRST) && (a <= bridge_pkg::ICU_B_LAST);
  endfunction

  function automatic logic isIcuA(input logic [31:0] a);
    isIcuA = (a >= bridge_pkg::ICU_A_FIRST) && (a <= bridge_pkg::ICU_A_LAST);
  endfunction

  function automatic logic [1:0] clkOf(input logic [31:0] a);
    logic [2:0] b;
    b = busOf(a);
    if (isIcuB(a)) begin
      clkOf = bridge_pkg::CLK_B;
    end else if (b == bridge_pkg::BUS_EXT) begin
      clkOf = bridge_pkg::CLK_EXT;
    end else if (b == 3'h6) begin
      clkOf = bridge_pkg::CLK_F;
    end else if (b == 3'h4 || b == 3'h5) begin
      clkOf = bridge_pkg::CLK_B;
    end else begin
      clkOf = bridge_pkg::CLK_A;
    end
  endfunction

  function automatic logic needsSync(input logic [31:0] a);
    logic [2:0] b;
    b = busOf(a);
    needsSync = (b >= 3'h2 && b <= 3'h6) ||
                (b == bridge_pkg::BUS_EXT && a > bridge_pkg::EXT_ERR_LAST);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Peripheral clock enables

  assign divs = {divExt, divF, divB, divA};

  generate
    for (genvar i = 0; i < bridge_pkg::NUM_CLKS; i++) begin : g_div
      clk_enable_divider u_div (
        .clk     (clk),
        .sys_rst (sys_rst),
        .div     (divs[i]),
        .enable  (en[i])
      );
    end
  endgenerate

  // Slow core sees the peripheral ready every core cycle
  assign effEn = coreSlower | en[st.clkSel];

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer

  always_comb begin
    next_st     = st;
    next_st.ack = 1'b0;
    if (st.cnt != bridge_pkg::CNT_MAX) begin
      next_st.cnt = st.cnt + 5'h01;
    end
    case (st.fsm)
      IDLE: begin
        if (reqValid && !busContend && !st.ack) begin
          next_st.fsm      = MAIN;
          next_st.tBus     = busOf(reqAddr);
          next_st.tAddr    = reqAddr;
          next_st.tWrite   = reqWrite;
          next_st.tSize    = reqSize;
          next_st.tWdata   = reqWdata;
          next_st.clkSel   = clkOf(reqAddr);
          next_st.sync     = needsSync(reqAddr);
          next_st.interrupt_control_unit      = isIcuA(reqAddr) | isIcuB(reqAddr);
          next_st.edgeSeen = 1'b0;
          next_st.cnt      = 5'h01;
        end
      end
      MAIN: begin
        // One main-bus cycle, then sync or straight to the target
        next_st.edgeSeen = effEn;
        if (st.interrupt_control_unit) begin
          next_st.fsm    = INTERRUPT_CONTROL_UNIT;
          next_st.tValid = 1'b1;
        end else if (st.sync && !coreSlower) begin
          next_st.fsm    = SYNC;
        end else begin
          next_st.fsm    = PERIPH;
          next_st.tValid = 1'b1;
        end
      end
      SYNC: begin
        // Wait for the target clock edge: at most one target clock
        if (effEn) begin
          next_st.fsm    = PERIPH;
          next_st.tValid = 1'b1;
        end
      end
      PERIPH: begin
        if (tgtAck && effEn) begin
          next_st.fsm    = IDLE;
          next_st.tValid = 1'b0;
          next_st.ack    = 1'b1;
          next_st.rdata  = tgtRdata;
        end
      end
      INTERRUPT_CONTROL_UNIT: begin
        // Two core cycles at least, ending by the next target edge
        if (effEn || st.edgeSeen) begin
          next_st.fsm    = IDLE;
          next_st.tValid = 1'b0;
          next_st.ack    = 1'b1;
          next_st.rdata  = tgtRdata;
        end
      end
      default: begin
        next_st.fsm    = IDLE;
        next_st.tValid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign reqAck   = st.ack;
  assign rdata    = st.rdata;
  assign tgtValid = st.tValid;
  assign tgtBus   = st.tBus;
  assign tgtAddr  = st.tAddr;
  assign tgtWrite = st.tWrite;
  assign tgtSize  = st.tSize;
  assign tgtWdata = st.tWdata;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_main_one_cycle: assert property (st.fsm == MAIN |=> st.fsm != MAIN)
    else $error("main-bus phase longer than one cycle");
  chk_sync_only_slow: assert property (st.fsm == SYNC |-> st.sync)
    else $error("sync cycles on a bus that needs none");
  chk_sync_bounded: assert property (st.fsm == SYNC |-> st.cnt <= 5'h11)
    else $error("sync wait exceeds one peripheral clock");
  chk_slow_restart: assert property (reqAck && coreSlower |-> st.fsm == IDLE)
    else $error("slow core not ready for next access");
  chk_ext_edge: assert property (st.fsm == SYNC && st.clkSel == bridge_pkg::CLK_EXT
      && !coreSlower && !en[bridge_pkg::CLK_EXT] |=> st.fsm == SYNC)
    else $error("external sync left without external edge");
  chk_start_free: assert property (st.fsm == MAIN |-> !$past(busContend))
    else $error("access started under contention");
  chk_icu_min: assert property (reqAck && st.interrupt_control_unit |-> st.cnt >= 5'h03)
    else $error("interrupt register access shorter than two core clocks");
  chk_icu_max: assert property (st.fsm == INTERRUPT_CONTROL_UNIT |-> st.cnt <= 5'h11)
    else $error("interrupt register access exceeds one peripheral clock");
  chk_icu_slow: assert property (st.fsm == INTERRUPT_CONTROL_UNIT && coreSlower |=> st.fsm == IDLE)
    else $error("slow-core interrupt access not two core clocks");
  chk_stall_ack: assert property (tgtValid && !st.interrupt_control_unit && !tgtAck |=> !reqAck)
    else $error("ack returned before target acknowledge");
  chk_ack_pulse: assert property (reqAck |=> !reqAck)
    else $error("ack longer than one cycle");

  cov_periph_access: cover property (st.fsm == PERIPH ##1 reqAck);
  cov_sync_access: cover property (st.fsm == SYNC ##[1:16] st.fsm == PERIPH);
  cov_icu_access: cover property (st.fsm == INTERRUPT_CONTROL_UNIT ##1 reqAck);
  cov_ext_access: cover property (st.fsm == SYNC && st.clkSel == bridge_pkg::CLK_EXT);
endmodule

// ---- bridge_pkg.sv ----
// Constants for the main-bus to peripheral-bus bridge
package bridge_pkg;
  // Address regions
  localparam logic [31:0] BUS1_BASE      = 32'h0008_0000;
  localparam logic [31:0] BUS2_BASE      = 32'h0009_0000;
  localparam logic [31:0] BUS3_BASE      = 32'h000a_0000;
  localparam logic [31:0] BUS4_BASE      = 32'h000b_0000;
  localparam logic [31:0] BUS5_BASE      = 32'h000c_0000;
  localparam logic [31:0] BUS6_BASE      = 32'h000d_0000;
  localparam logic [31:0] EXT_BASE       = 32'h000e_0000;
  localparam logic [31:0] EXT_ERR_LAST   = 32'h000e_00ff;
  localparam logic [31:0] EXT_LAST       = 32'h000e_ffff;
  localparam logic [31:0] ICU_B_FIRST    = 32'h0008_77bc;
  localparam logic [31:0] ICU_B_LAST     = 32'h0008_77cf;
  localparam logic [31:0] ICU_A_FIRST    = 32'h0008_7830;
  localparam logic [31:0] ICU_A_LAST     = 32'h0008_79d1;
  // Target bus codes
  localparam logic [2:0]  BUS_NONE       = 3'h0;
  localparam logic [2:0]  BUS_EXT        = 3'h7;
  // Clock enable selectors
  localparam logic [1:0]  CLK_A          = 2'h0;
  localparam logic [1:0]  CLK_B          = 2'h1;
  localparam logic [1:0]  CLK_F          = 2'h2;
  localparam logic [1:0]  CLK_EXT        = 2'h3;
  localparam int          NUM_CLKS       = 4;
  // Timing
  localparam logic [4:0]  ICU_MIN_CYCLES = 5'h02;
  localparam logic [4:0]  CNT_MAX        = 5'h1f;
  localparam logic [3:0]  DIV_RESET      = 4'h0;
endpackage

// ---- clk_enable_divider.sv ----
// Divider that produces a one-cycle enable every div+1 core cycles
`timescale 1ns/10ps
module clk_enable_divider (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [3:0] div,
  output logic            enable
);
  logic [3:0] count;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count  <= bridge_pkg::DIV_RESET;
      enable <= 1'b0;
    end else if (count >= div) begin
      count  <= bridge_pkg::DIV_RESET;
      enable <= 1'b1;
    end else begin
      count  <= count + 4'h1;
      enable <= 1'b0;
    end
  end
endmodule

// ---- target_model.sv ----
// Far-side peripheral register target answering the bridge
`timescale 1ns/10ps
module target_model (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        tgtValid,
  input  wire logic [31:0] tgtAddr,
  input  wire logic [1:0]  lat,
  output logic             tgtAck,
  output logic [31:0]      tgtRdata
);
  logic [1:0] cnt;
  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      cnt <= 2'h0;
    else if (!tgtValid)
      cnt <= 2'h0;
    else if (cnt != lat)
      cnt <= cnt + 2'h1;
  end
  // Acknowledge held until the bridge drops its request
  assign tgtAck = tgtValid && (cnt == lat);
  // Data only while selected, inverted pattern otherwise
  assign tgtRdata = tgtValid ? (tgtAddr ^ 32'h5a5a_c3c3) : ~(tgtAddr ^ 32'h5a5a_c3c3);
endmodule

// ---- peripheral_bus_access_timing_test.sv ----
// Self-checking bench for the main-bus to peripheral-bus bridge
`timescale 1ns/10ps
module peripheral_bus_access_timing_test;
  logic        clk = 1'b0, sys_rst = 1'b1, reqValid = 1'b0, reqWrite = 1'b0;
  logic        busContend = 1'b0, coreSlower = 1'b0;
  logic [31:0] reqAddr = 32'h0, reqWdata = 32'h0;
  logic [1:0]  reqSize = 2'h0, lat = 2'h0;
  logic [3:0]  divs [4] = '{4'h0, 4'h0, 4'h0, 4'h0};
  logic        reqAck, tgtValid, tgtAck, tgtWrite;
  logic [31:0] rdata, tgtAddr, tgtWdata, tgtRdata;
  logic [2:0]  tgtBus;
  logic [1:0]  tgtSize;
  int          error_cnt = 0, num_checks = 0;

  always #2.5 clk = ~clk;

  peripheral_bus_bridge i_dut (.clk(clk), .sys_rst(sys_rst), .reqValid(reqValid),
    .reqAddr(reqAddr), .reqWrite(reqWrite), .reqSize(reqSize), .reqWdata(reqWdata),
    .busContend(busContend), .coreSlower(coreSlower), .divA(divs[0]), .divB(divs[1]),
    .divF(divs[2]), .divExt(divs[3]), .tgtAck(tgtAck), .tgtRdata(tgtRdata),
    .reqAck(reqAck), .rdata(rdata), .tgtValid(tgtValid), .tgtBus(tgtBus),
    .tgtAddr(tgtAddr), .tgtWrite(tgtWrite), .tgtSize(tgtSize), .tgtWdata(tgtWdata));
  target_model i_tgt (.clk(clk), .sys_rst(sys_rst), .tgtValid(tgtValid),
    .tgtAddr(tgtAddr), .lat(lat), .tgtAck(tgtAck), .tgtRdata(tgtRdata));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Regions: 0..5 buses, 6 external, 7 bus-error, 8..10 interrupt, 11 unmapped
  function automatic logic [31:0] addrOf(input int r, input logic [31:0] x);
    case (r)
      0: return bridge_pkg::BUS1_BASE + {20'h0, x[11:0]};
      1, 2, 3, 4, 5: return bridge_pkg::BUS1_BASE + (32'(r) << 16) + {16'h0, x[15:0]};
      6: return bridge_pkg::EXT_BASE + 32'h100 + {24'h0, x[7:0]};
      7: return bridge_pkg::EXT_BASE + {24'h0, x[7:0]};
      8: return bridge_pkg::ICU_B_FIRST + 32'(x % 20);
      9: return bridge_pkg::ICU_A_FIRST;
      10: return bridge_pkg::ICU_A_LAST;
      default: return 32'h0010_0000 + {16'h0, x[15:0]};
    endcase
  endfunction

  function automatic logic [2:0] busOf(input int r);
    if (r == 0 || (r > 7 && r < 11))
      return 3'h1;
    if (r < 6)
      return 3'(r + 1);
    return (r < 8) ? bridge_pkg::BUS_EXT : bridge_pkg::BUS_NONE;
  endfunction

  function automatic int clkOf(input int r);
    if (r inside {3, 4, 8})
      return int'(bridge_pkg::CLK_B);
    if (r == 5)
      return int'(bridge_pkg::CLK_F);
    return (r inside {6, 7}) ? int'(bridge_pkg::CLK_EXT) : int'(bridge_pkg::CLK_A);
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  // Called just after an edge; leaves the request up for a back-to-back follower
  task automatic access(input int r, input int hold, input bit rdOnly = 1'b0);
    logic [31:0] a, d;
    logic        w;
    int          n, dv, hi;
    a = addrOf(r, $urandom);
    d = $urandom;
    w = rdOnly ? 1'b0 : 1'($urandom);
    dv = coreSlower ? 0 : int'(divs[clkOf(r)]);
    hi = (r > 7 && r < 11) ? dv + 2 : (dv + 1) * (int'(lat) + 3) + 3;
    reqValid <= 1'b1;
    reqAddr <= a;
    reqWrite <= w;
    reqWdata <= d;
    reqSize <= (r == 9) ? 2'h2 : 2'h0;
    if (hold > 0)
      busContend <= 1'b1;
    repeat (hold) begin
      @(posedge clk);
      #1;
      chk("idle while contended", 32'({reqAck, tgtValid}), 32'h0);
    end
    busContend <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (reqAck !== 1'b1 && n < 300);
    if (n >= 300) begin
      chk("ack timeout", 32'h0, 32'h1);
      report_and_stop();
    end
    chk("cycles", 32'(n - 1 >= 2 && n - 1 <= hi), 32'h1);
    if (r > 7 && r < 11)
      chk("icu cycles", 32'(n - 1 <= dv + 2), 32'h1);
    if (coreSlower && r > 7 && r < 11)
      chk("slow icu cycles", 32'(n - 1), 32'h2);
    chk("size", 32'(tgtSize), (r == 9) ? 32'h2 : 32'h0);
    if (!w)
      chk("rdata", rdata, a ^ 32'h5a5a_c3c3);
    chk("bus", 32'(tgtBus), 32'(busOf(r)));
    chk("addr", tgtAddr, a);
    chk("write", 32'(tgtWrite), 32'(w));
    chk("wdata", tgtWdata, d);
    chk("valid after done", 32'(tgtValid), 32'h0);
    @(posedge clk);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(46129));
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    // No sleep-mode or block-instruction traffic
    for (int i = 0; i < 48; i++) begin
      if (i % 12 == 0) begin
        reqValid <= 1'b0;
        @(posedge clk);
        foreach (divs[k])
          divs[k] <= 4'($urandom % 4);
        lat <= 2'($urandom);
        coreSlower <= (i >= 36);
        @(posedge clk);
      end
      access((i < 12) ? i : int'($urandom % 12), (i < 12) ? 2 : int'($urandom % 3));
      if (i % 12 == 11)
        $display("test %0d done", i / 12);
    end
    access(8, 0);
    access(9, 0);
    access(10, 0);
    access(10, 0, 1'b1);
    $display("test back-to-back done");
    report_and_stop();
  end
endmodule
